// ===== hw/scr_holdoff.sv
// System counter with clear, hold and sticky timeout flag
`timescale 1ns/1ns
`default_nettype none
`include "scr_defs.svh"
module scr_holdoff #(
    parameter int CW = `SCR_CNT_W,
    parameter int LONG_CYC = `SCR_LONG_HOLD_CYC,
    parameter int SHORT_CYC = `SCR_SHORT_HOLD_CYC
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic run_in,
    input wire logic short_in,
    output logic [CW-1:0] count_out,
    output logic done_out
);
    logic [CW-1:0] next_count;
    logic next_done;
    logic [CW-1:0] last;

    // Count, clear to zero, latch the selected timeout
    always_comb begin
        last = short_in ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1); // R08
        next_count = count_out;
        next_done = done_out;
        if (clear_in) begin
            next_count = '0; // R10
            next_done = 1'b0;
        end else if (run_in) begin
            next_count = count_out + CW'(1); // R06
            next_done = done_out | (count_out == last);
        end
    end

    // Counter registers
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_out <= '0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            count_out <= next_count;
            done_out <= next_done;
        end
    end
endmodule
`default_nettype wire

// ===== hw/scr_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module scr_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_level;

    // Accept a change once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
        end
    end

    // Synchroniser chain
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            level_out <= RST_VAL;
        end else if (ce_in) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end
endmodule
`default_nettype wire

// ===== hw/scr_top.sv
// Bus clock generation, clock hold-off sequencing and status registers
// Contract
// R01 - Divide oscillator by two for half-rate clock, again by two for bus clocks.
// R02 - Bus clock runs at oscillator frequency divided by four.
// R03 - After power-on hold CPU and peripheral clocks inactive for 4096 cycles.
// R04 - Drive the reset pin low during the whole power-on hold.
// R05 - Start bus clocks as soon as the power-on hold completes.
// R06 - Leaving stop by interrupt, break or reset lets the counter advance.
// R07 - Keep CPU and peripheral clocks inactive until stop recovery expires.
// R08 - Stop recovery delay is 4096 or 32 oscillator cycles.
// R09 - Short recovery bit one selects 32 cycles, zero selects 4096.
// R10 - Stop entry clears the system counter so recovery counts from zero.
// R11 - Writing zero to break status bit 1 clears the stop/wait flag.
// R12 - Reset cause register is read-only; power-on sets only its top bit.
// R13 - Break flag control bit 7 is the break clear enable, reset zero.
// R14 - During break, status bits clear only when break clear enable is one.
// R15 - Pending register low shows sources 6 to 1 in bits 7 to 2.
// R16 - Pending register high shows sources 14 to 7 in bits 7 to 0.
// R17 - Accept sixteen interrupt sources and present the highest-priority request.
// R18 - Hold internal reset through hold-off; release clocks on a phase boundary.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "scr_defs.svh"
module scr_top import scr_pkg::*; #(
    parameter int NUM_SRC = 16,
    parameter int LONG_HOLD_CYC = `SCR_LONG_HOLD_CYC,
    parameter int SHORT_HOLD_CYC = `SCR_SHORT_HOLD_CYC
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic power_on_pulse_in,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_out,
    input wire logic stop_req_in,
    input wire logic wait_in,
    input wire logic break_in,
    input wire logic watchdog_rst_in,
    input wire logic bad_opcode_in,
    input wire logic bad_fetch_in,
    input wire logic usb_rst_in,
    input wire logic [NUM_SRC-1:0] int_src_in,
    output logic half_rate_clk_out,
    output logic cpu_clk_out,
    output logic periph_clk_out,
    output logic internal_reset_out,
    output logic irq_req_out,
    output logic [4:0] irq_vec_out,
    output logic irq_out,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [`SCR_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    scr_state_t state, next_state;
    logic [1:0] div, next_div;
    logic [`SCR_CNT_W-1:0] cnt;
    logic cnt_done, cnt_clear, cnt_short;
    logic por_lvl, pin_lvl, rst_evt, wake, boundary;
    logic next_pin_oe, next_internal_reset, next_cpu_clk, next_periph_clk;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [`SCR_IDX_W-1:0] idx;
    logic wr_en, clr_ok;
    logic break_stop_wait_flag, next_break_stop_wait_flag, break_q, break_stop_wait_flag_set;
    logic break_clear_enable, next_break_clear_enable, short_stop_recovery, next_short_stop_recovery;
    scr_byte_t rst_cause, next_rst_cause, cause_vec;
    logic [NUM_SRC-1:0] pend, next_pend;
    logic [`SCR_EVT_W-1:0] evt, next_evt, evt_set, evt_w1c, mask, next_mask;
    logic next_irq_req, next_irq;
    logic [4:0] next_vec;

    // Lowest numbered pending source wins, coded from one
    function automatic logic [4:0] prio_vec(input logic [NUM_SRC-1:0] p);
        logic [4:0] v;
        v = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                v = 5'(i + 1);
            end
        end
        return v;
    endfunction

    // Read data of one register index
    function automatic scr_byte_t read_reg(input logic [`SCR_IDX_W-1:0] i);
        scr_byte_t r;
        r = 8'h00;
        unique case (i)
            `SCR_IDX_BREAK: r[`SCR_BIT_BREAK_STOP_WAIT_FLAG] = break_stop_wait_flag;
            `SCR_IDX_RST_CAUSE: r = rst_cause; // R12
            `SCR_IDX_BRK_CTRL: r[`SCR_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable; // R13
            `SCR_IDX_PEND_LOW: r = {pend[5:0], 2'b00}; // R15
            `SCR_IDX_PEND_HIGH: r = pend[13:6]; // R16
            `SCR_IDX_SYS_CFG: r[`SCR_BIT_SHORT_STOP_RECOVERY] = short_stop_recovery;
            `SCR_IDX_EVT_STAT: r = {4'h0, evt};
            `SCR_IDX_EVT_MASK: r = {4'h0, mask};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and system counter
    // ------------------------------------------------------------
    scr_sync3 #(.W(2), .RST_VAL(2'b01)) u_sync (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .async_in({power_on_pulse_in, rst_pin_in}),
        .level_out({por_lvl, pin_lvl})
    );

    scr_holdoff #(.LONG_CYC(LONG_HOLD_CYC), .SHORT_CYC(SHORT_HOLD_CYC)) u_cnt (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .clear_in(cnt_clear),
        .run_in(state != ST_STOP),
        .short_in(cnt_short),
        .count_out(cnt),
        .done_out(cnt_done)
    );

    // ------------------------------------------------------------
    // Clock sequencer
    // ------------------------------------------------------------
    // Next state, divider and gated clock outputs
    always_comb begin
        next_div = div + 2'b01; // R01
        boundary = (div == 2'b11); // R18
        cnt_short = (state == ST_STOP_RECOVER) && short_stop_recovery; // R09
        rst_evt = watchdog_rst_in | bad_opcode_in | bad_fetch_in | usb_rst_in;
        if (state == ST_RUN || state == ST_STOP || state == ST_STOP_RECOVER) begin
            rst_evt = rst_evt | ~pin_lvl;
        end
        if (state == ST_POR_HOLD) begin
            rst_evt = 1'b0;
        end
        wake = (|int_src_in) | break_in;
        next_state = state;
        unique case (state)
            ST_POR_HOLD: if (cnt_done && boundary) next_state = ST_RUN; // R05
            ST_RST_HOLD: if (cnt >= `SCR_CNT_W'(`SCR_RST_INT_CYC - 1) && boundary) next_state = ST_RUN;
            ST_RUN: if (stop_req_in && boundary) next_state = ST_STOP;
            ST_STOP: if (wake) next_state = ST_STOP_RECOVER; // R06
            ST_STOP_RECOVER: if (cnt_done && boundary) next_state = ST_RUN; // R07
        endcase
        if (rst_evt) begin
            next_state = ST_RST_HOLD;
        end
        if (por_lvl) begin
            next_state = ST_POR_HOLD;
        end
        cnt_clear = por_lvl | rst_evt | (state == ST_RUN && next_state == ST_STOP); // R10
        next_pin_oe = (next_state == ST_POR_HOLD) // R04
            || (next_state == ST_RST_HOLD && (cnt_clear || cnt < `SCR_CNT_W'(`SCR_RST_PIN_CYC - 1)));
        next_internal_reset = (next_state == ST_POR_HOLD) || (next_state == ST_RST_HOLD)
            || (next_state == ST_STOP_RECOVER); // R18
        next_periph_clk = (next_state == ST_RUN) && next_div[1]; // R02 R03
        next_cpu_clk = next_periph_clk && !wait_in;
    end

    // Sequencer and clock output registers
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ST_POR_HOLD;
            div <= 2'b00;
            half_rate_clk_out <= 1'b0;
            cpu_clk_out <= 1'b0;
            periph_clk_out <= 1'b0;
            internal_reset_out <= 1'b1;
            rst_pin_out <= 1'b0;
            rst_pin_oe_out <= 1'b1;
        end else if (ce_in) begin
            state <= next_state;
            div <= next_div;
            half_rate_clk_out <= next_div[0];
            cpu_clk_out <= next_cpu_clk;
            periph_clk_out <= next_periph_clk;
            internal_reset_out <= next_internal_reset;
            rst_pin_out <= 1'b0;
            rst_pin_oe_out <= next_pin_oe;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave and status registers
    // ------------------------------------------------------------
    // Decode, write effects and sticky flags
    always_comb begin
        idx = wb_adr_in[`SCR_ADR_W-1:2];
        next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
        next_rdata = next_ack ? {24'h000000, read_reg(idx)} : 32'h00000000;
        wr_en = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] && wb_adr_in[1:0] == 2'b00;
        clr_ok = !break_in || break_clear_enable; // R14
        break_stop_wait_flag_set = break_in && !break_q && (state == ST_STOP || wait_in);
        next_break_stop_wait_flag = break_stop_wait_flag_set | break_stop_wait_flag; // R11
        if (wr_en && idx == `SCR_IDX_BREAK && !wb_dat_in[`SCR_BIT_BREAK_STOP_WAIT_FLAG] && clr_ok && !break_stop_wait_flag_set) begin
            next_break_stop_wait_flag = 1'b0; // R11
        end
        next_break_clear_enable = break_clear_enable;
        next_short_stop_recovery = short_stop_recovery;
        next_mask = mask;
        evt_w1c = 4'h0;
        if (wr_en && idx == `SCR_IDX_BRK_CTRL) next_break_clear_enable = wb_dat_in[`SCR_BIT_BREAK_CLEAR_ENABLE]; // R13
        if (wr_en && idx == `SCR_IDX_SYS_CFG) next_short_stop_recovery = wb_dat_in[`SCR_BIT_SHORT_STOP_RECOVERY]; // R09
        if (wr_en && idx == `SCR_IDX_EVT_MASK) next_mask = wb_dat_in[`SCR_EVT_W-1:0];
        if (wr_en && idx == `SCR_IDX_EVT_STAT && clr_ok) evt_w1c = wb_dat_in[`SCR_EVT_W-1:0]; // R14
        cause_vec = {1'b0, state != ST_POR_HOLD && ~pin_lvl && rst_evt, watchdog_rst_in, bad_opcode_in,
            bad_fetch_in, usb_rst_in, 2'b00};
        next_rst_cause = rst_cause;
        if (por_lvl) begin
            next_rst_cause = `SCR_RST_CAUSE_POR; // R12
        end else if (rst_evt) begin
            next_rst_cause = cause_vec;
        end
        evt_set = 4'h0;
        evt_set[`SCR_EVT_HOLD_DONE] = (state == ST_POR_HOLD || state == ST_RST_HOLD) && next_state == ST_RUN;
        evt_set[`SCR_EVT_STOP_EXIT] = state == ST_STOP_RECOVER && next_state == ST_RUN;
        evt_set[`SCR_EVT_RST_CAUSE] = rst_evt;
        evt_set[`SCR_EVT_BRK_STOP] = break_stop_wait_flag_set;
        next_evt = (evt & ~evt_w1c) | evt_set;
        next_irq = |(next_evt & next_mask);
        next_pend = int_src_in; // R17
        next_irq_req = |next_pend;
        next_vec = prio_vec(next_pend); // R17
    end

    // Bus and register state
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
            break_stop_wait_flag <= 1'b0;
            break_q <= 1'b0;
            break_clear_enable <= 1'b0;
            short_stop_recovery <= 1'b0;
            rst_cause <= `SCR_RST_CAUSE_POR;
            evt <= 4'h0;
            mask <= `SCR_EVT_MASK_RESET;
            pend <= '0;
            irq_out <= 1'b0;
            irq_req_out <= 1'b0;
            irq_vec_out <= 5'h00;
        end else if (ce_in) begin
            wb_ack_out <= next_ack;
            wb_dat_out <= next_rdata;
            break_stop_wait_flag <= next_break_stop_wait_flag;
            break_q <= break_in;
            break_clear_enable <= next_break_clear_enable;
            short_stop_recovery <= next_short_stop_recovery;
            rst_cause <= next_rst_cause;
            evt <= next_evt;
            mask <= next_mask;
            pend <= next_pend;
            irq_out <= next_irq;
            irq_req_out <= next_irq_req;
            irq_vec_out <= next_vec;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [12:0] hold_cnt;

    // Enabled cycles spent in the current hold state
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hold_cnt <= 13'h0000;
        end else if (ce_in) begin
            if (next_state != state) begin
                hold_cnt <= 13'h0000;
            end else if (hold_cnt != 13'h1FFF) begin
                hold_cnt <= hold_cnt + 13'h0001;
            end
        end
    end

    chk_bus_quarter: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R02
        $rose(periph_clk_out) ##0 (ce_in && state == ST_RUN)[*4] ##1 (state == ST_RUN) |-> $rose(periph_clk_out))
        else $error("bus clock period is not four oscillator cycles");
    chk_por_length: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R03
        $fell(state == ST_POR_HOLD) && state == ST_RUN |-> $past(hold_cnt) >= 13'(LONG_HOLD_CYC - 1))
        else $error("power-on hold ended early");
    chk_por_pin: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R04
        state == ST_POR_HOLD |-> rst_pin_oe_out && !rst_pin_out && internal_reset_out && !periph_clk_out)
        else $error("reset pin or clocks wrong during power-on hold");
    chk_bus_start: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R05
        $fell(state == ST_POR_HOLD) && state == ST_RUN ##0 (ce_in && state == ST_RUN)[*2] |=> periph_clk_out)
        else $error("bus clock did not start after power-on hold");
    chk_stop_idle: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R07
        state == ST_STOP || state == ST_STOP_RECOVER |-> !cpu_clk_out && !periph_clk_out)
        else $error("clocks active during stop or recovery");
    chk_recover_len: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R09
        $past(state) == ST_STOP_RECOVER && state == ST_RUN
        |-> hold_cnt == 13'h0000 && $past(hold_cnt) >= 13'(($past(short_stop_recovery) ? SHORT_HOLD_CYC : LONG_HOLD_CYC) - 1))
        else $error("stop recovery shorter than selected delay");
    chk_stop_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R10
        $rose(state == ST_STOP) |-> cnt == '0 ##1 (state != ST_STOP || cnt == '0))
        else $error("system counter not cleared and held in stop");
    chk_break_stop_wait_flag_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R11
        ce_in && wr_en && idx == `SCR_IDX_BREAK && !wb_dat_in[`SCR_BIT_BREAK_STOP_WAIT_FLAG] && clr_ok && !break_stop_wait_flag_set |=> !break_stop_wait_flag)
        else $error("break stop/wait flag not cleared by zero write");
    chk_por_cause: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R12
        $fell(state == ST_POR_HOLD) |-> rst_cause == `SCR_RST_CAUSE_POR)
        else $error("reset cause wrong after power-on");
    chk_break_keep: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R14
        break_in && !break_clear_enable && wr_en && idx == `SCR_IDX_EVT_STAT |=> (evt & $past(evt)) == $past(evt))
        else $error("status cleared during break while clear disabled");
    chk_pend_low: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // R15
        wb_ack_out && !wb_we_in && idx == `SCR_IDX_PEND_LOW
        |-> wb_dat_out[7:2] == $past(int_src_in[5:0], 2) && wb_dat_out[1:0] == 2'b00 && wb_dat_out[31:8] == '0)
        else $error("pending low register bits wrong");

    cov_por_done: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) $fell(state == ST_POR_HOLD));
    cov_short_rec: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        state == ST_STOP_RECOVER && short_stop_recovery ##1 state == ST_RUN);
    cov_pin_reset: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) rst_cause[6]);
    cov_brk_stop: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) break_stop_wait_flag_set && state == ST_STOP);
endmodule
`default_nettype wire

// ===== shared/scr_defs.svh
// Offsets, field positions, reset values and hold-off counts of the clock and reset status block
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------
`define SCR_ADR_W 18
`define SCR_IDX_W 16
`define SCR_IDX_BREAK 16'hFE00
`define SCR_IDX_RST_CAUSE 16'hFE01
`define SCR_IDX_BRK_CTRL 16'hFE03
`define SCR_IDX_PEND_LOW 16'hFE04
`define SCR_IDX_PEND_HIGH 16'hFE05
`define SCR_IDX_SYS_CFG 16'hFE06
`define SCR_IDX_EVT_STAT 16'hFE07
`define SCR_IDX_EVT_MASK 16'hFE08

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SCR_BIT_BREAK_STOP_WAIT_FLAG 1
`define SCR_BIT_BREAK_CLEAR_ENABLE 7
`define SCR_BIT_SHORT_STOP_RECOVERY 0
`define SCR_PEND_LOW_LSB 2
`define SCR_RST_CAUSE_POR 8'h80
`define SCR_EVT_W 4
`define SCR_EVT_HOLD_DONE 0
`define SCR_EVT_STOP_EXIT 1
`define SCR_EVT_RST_CAUSE 2
`define SCR_EVT_BRK_STOP 3
`define SCR_EVT_MASK_RESET 4'h0

// ------------------------------------------------------------
// Hold-off counts in oscillator cycles
// ------------------------------------------------------------
`define SCR_CNT_W 12
`define SCR_LONG_HOLD_CYC 4096
`define SCR_SHORT_HOLD_CYC 32
`define SCR_RST_PIN_CYC 32
`define SCR_RST_INT_CYC 64

`endif

// ===== shared/scr_pkg.sv
// Types of the clock and reset status block
`default_nettype none
package scr_pkg;
    // Clock sequencer states
    typedef enum logic [2:0] {
        ST_POR_HOLD,
        ST_RST_HOLD,
        ST_RUN,
        ST_STOP,
        ST_STOP_RECOVER
    } scr_state_t;
    typedef logic [7:0] scr_byte_t;
endpackage
`default_nettype wire

// ===== tb/scr_cpu_model.sv
// Model of the processor side that requests stop mode
`timescale 1ns/1ns
`default_nettype none
module scr_cpu_model (
    input wire logic ref_clk_in,
    input wire logic go_in,
    input wire logic periph_clk_in,
    output logic stop_req_out
);
    int low_cnt;
    // Raise on go, hold until the bus clock sits low for 8 cycles
    initial begin
        stop_req_out = 1'b0;
        low_cnt = 0;
        forever begin
            @(posedge ref_clk_in);
            if (go_in && !stop_req_out) begin
                stop_req_out <= 1'b1;
                low_cnt = 0;
            end else if (stop_req_out) begin
                low_cnt = periph_clk_in ? 0 : low_cnt + 1;
                if (low_cnt == 8) stop_req_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/system_clock_and_reset_status_test.sv
// Self-checking bench of the clock and reset status block
`timescale 1ns/1ns
`default_nettype none
module system_clock_and_reset_status_test;
    logic clk = 1'b0;
    logic rst_n, go, stop_req, wt, brk, req, we, ack;
    logic cpu_clk, per_clk, half_clk, internal_reset, oe, irq, irq_req, pin, pin_d;
    logic [3:0] evt;
    logic [15:0] src;
    logic [17:0] adr;
    logic [31:0] wdat, rdat;
    logic [4:0] vec;
    logic [7:0] q;
    int err_total, compares, n;

    // Device with a shortened power-on hold
    scr_top #(.LONG_HOLD_CYC(64)) i_scr_top (.ref_clk_in(clk), .arst_n_in(rst_n), .ce_in(1'b1),
        .power_on_pulse_in(1'b0), .rst_pin_in(pin), .rst_pin_out(pin_d), .rst_pin_oe_out(oe),
        .stop_req_in(stop_req), .wait_in(wt), .break_in(brk), .watchdog_rst_in(evt[0]),
        .bad_opcode_in(evt[1]), .bad_fetch_in(evt[2]), .usb_rst_in(evt[3]), .int_src_in(src),
        .half_rate_clk_out(half_clk), .cpu_clk_out(cpu_clk), .periph_clk_out(per_clk),
        .internal_reset_out(internal_reset), .irq_req_out(irq_req), .irq_vec_out(vec), .irq_out(irq),
        .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
    scr_cpu_model i_scr_cpu_model (.ref_clk_in(clk), .go_in(go), .periph_clk_in(per_clk),
        .stop_req_out(stop_req));

    // 20 MHz oscillator
    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask

    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        req <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(q, exp, "register read");
    endtask

    task automatic wait_run(output int c);
        c = 0;
        while (cpu_clk !== 1'b1) begin
            @(posedge clk);
            c++;
        end
    endtask

    task automatic t_por;
        logic [7:0] v, h;
        check({pin_d, oe, internal_reset, cpu_clk}, 4'b0110, "held at power-on");
        wait_run(n);
        check(n >= 64 && n <= 76, 1'b1, "power-on hold length");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            v = {v[6:0], cpu_clk};
            h = {h[6:0], half_clk};
        end
        check(v == 8'hCC || v == 8'h66 || v == 8'h33 || v == 8'h99, 1'b1, "bus clock");
        check(h == 8'hAA || h == 8'h55, 1'b1, "half rate");
        check({oe, internal_reset}, 2'b00, "released after hold");
        $display("done power-on");
    endtask

    task automatic t_regs;
        rd(16'hFE00, 8'h00);
        rd(16'hFE01, 8'h80);
        rd(16'hFE03, 8'h00);
        rd(16'hFE02, 8'h00);
        wb(1'b1, 16'hFE01, 8'h00);
        rd(16'hFE01, 8'h80);
        wb(1'b1, 16'hFE03, 8'h80);
        rd(16'hFE03, 8'h80);
        wb(1'b1, 16'hFE03, 8'h00);
        src <= 16'h2045;
        repeat (4) @(posedge clk);
        rd(16'hFE04, 8'h14);
        rd(16'hFE05, 8'h81);
        check({irq_req, vec}, 6'h21, "lowest pending source");
        src <= 16'h0000;
        $display("done registers");
    endtask

    task automatic t_cause;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            evt[i] <= 1'b1;
            @(posedge clk);
            evt <= 4'h0;
            repeat (8) @(posedge clk);
            check({oe, internal_reset, cpu_clk}, 3'b110, "reset hold");
            rd(16'hFE01, 8'h20 >> i);
            wait_run(n);
        end
        // Pin reset: filtered low level starts a reset hold
        pin <= 1'b0;
        repeat (8) @(posedge clk);
        pin <= 1'b1;
        check({pin_d, oe, internal_reset, cpu_clk}, 4'b0110, "pin reset hold");
        rd(16'hFE01, 8'h40);
        wait_run(n);
        $display("done reset causes");
    endtask

    task automatic t_stop(input logic sh);
        wb(1'b1, 16'hFE06, {7'h00, sh});
        wb(1'b1, 16'hFE08, 8'h02);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "masked event");
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        check({cpu_clk, per_clk}, 2'b00, "clocks stopped in stop");
        src[0] <= 1'b1;
        repeat (3) @(posedge clk);
        check(internal_reset, 1'b1, "reset during recovery");
        wait_run(n);
        check(n + 3 >= (sh ? 32 : 64) && n + 3 <= (sh ? 44 : 76), 1'b1, "stop recovery length");
        src <= 16'h0000;
        rd(16'hFE07, sh ? 8'h07 : 8'h02);
        check(irq, 1'b1, "unmasked event");
        wb(1'b1, 16'hFE07, 8'h0F);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "event cleared");
        wb(1'b1, 16'hFE08, 8'h00);
        $display("done stop recovery");
    endtask

    task automatic t_break;
        wt <= 1'b1;
        brk <= 1'b1;
        repeat (3) @(posedge clk);
        rd(16'hFE00, 8'h02);
        wb(1'b1, 16'hFE00, 8'h00);
        rd(16'hFE00, 8'h02);
        wb(1'b1, 16'hFE07, 8'h08);
        rd(16'hFE07, 8'h08);
        wb(1'b1, 16'hFE03, 8'h80);
        wb(1'b1, 16'hFE00, 8'h00);
        rd(16'hFE00, 8'h00);
        wb(1'b1, 16'hFE07, 8'h08);
        rd(16'hFE07, 8'h00);
        brk <= 1'b0;
        wt <= 1'b0;
        wb(1'b1, 16'hFE03, 8'h00);
        $display("done break flag");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        err_total++;
        results;
    end

    initial begin
        {rst_n, go, wt, brk, req, we, evt, src, adr, wdat} = '0;
        pin = 1'b1;
        err_total = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_por;
        t_regs;
        t_cause;
        t_stop(1'b1);
        t_stop(1'b0);
        t_break;
        results;
    end
endmodule
`default_nettype wire
